// ===== logic/emb_pkg.sv
// constants, types and reset values for the external memory bus block
// assumes one oscillator-rate clock; every bus phase is counted on it
package emb_pkg;

   // ------------------------------------------------------------
   // machine cycle phases (twelve half-states per machine cycle)
   // ------------------------------------------------------------
   localparam logic [3:0] PH_FIRST = 4'h0;
   localparam logic [3:0] PH_LAST = 4'hb;
   localparam logic [3:0] PH_STEP_12 = 4'h1;
   localparam logic [3:0] PH_STEP_6 = 4'h2;
   localparam logic [3:0] PH_ALE_END = 4'h1;
   localparam logic [3:0] PH_HALF = 4'h6;
   localparam logic [3:0] PH_ALE2_END = 4'h7;
   localparam logic [3:0] PH_ADDR_END = 4'h2;
   localparam logic [3:0] PH_STB_FIRST = 4'h3;
   localparam logic [3:0] PH_WR_END = 4'ha;

   // ------------------------------------------------------------
   // reset pin qualification, in oscillator periods (two machine cycles)
   // ------------------------------------------------------------
   localparam logic [4:0] RST_OSC_12 = 5'h18;
   localparam logic [4:0] RST_OSC_6 = 5'h0c;
   localparam logic [1:0] CAP_DONE = 2'h2;

   // ------------------------------------------------------------
   // commands from the core and bus cycle states
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      CMD_IDLE = 2'h0,
      CMD_FETCH = 2'h1,
      CMD_XRD = 2'h2,
      CMD_XWR = 2'h3
   } emb_kind_t;

   typedef struct packed {
      emb_kind_t kind;
      logic wide;
      logic [15:0] addr;
      logic [7:0] wdata;
   } emb_cmd_t;

   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_INT = 4'h2,
      ST_EXT = 4'h4,
      ST_EXTERNAL_MOVE_INSTRUCTION = 4'h8
   } emb_state_t;

   typedef struct packed {
      logic ale;
      logic code_read_strobe_n;
      logic wr_n;
      logic rd_n;
      logic [7:0] p0_o;
      logic [7:0] p0_oe;
      logic [7:0] p2;
   } emb_pins_t;

   localparam emb_cmd_t CMD_RST = '{kind: CMD_IDLE, wide: 1'b0, addr: 16'h0000, wdata: 8'h00};
   localparam emb_pins_t PINS_RST = '{ale: 1'b0, code_read_strobe_n: 1'b1, wr_n: 1'b1, rd_n: 1'b1,
                                      p0_o: 8'h00, p0_oe: 8'h00, p2: 8'hff};

endpackage

// ===== logic/emb_sync.sv
// two-flop synchroniser for pin inputs
// assumes the pin may change at any time relative to mclk_i
`timescale 1ns/10ps
module emb_sync #(
   parameter int unsigned W = 1
) (
   input wire logic mclk_i,
   input wire logic arst_n_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);

   logic [W-1:0] meta_r;
   logic [W-1:0] q_r;

   // first stage is read by the second stage only
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         meta_r <= '0;
         q_r <= '0;
      end else begin
         meta_r <= d_i;
         q_r <= meta_r;
      end
   end

   assign q_o = q_r;

endmodule // emb_sync

// ===== logic/emb_bus.sv
// external program and data memory bus of an 8-bit controller
// assumes mclk_i is the oscillator and the core issues one command per machine cycle
//
// Summary of operation
// R01 - low address byte and data share the low address/data port in time
// R02 - bus ones on that port are driven high, not left floating
// R03 - outside bus cycles, port bits latched one float as inputs
// R04 - high address port carries address high byte on code fetch and wide moves; internal code fetches show the high port latch instead
// R05 - narrow external moves put the high port latch on the high port
// R06 - address latch strobe pulses at osc/6, or osc/3 in 6-clock mode
// R07 - each external data access drops exactly one address latch pulse
// R08 - latch strobe disable bit silences it except during external moves
// R09 - external code execution gives two code-read strobes per machine cycle
// R10 - each external data access skips two code-read strobes
// R11 - internal code fetches never raise the code-read strobe
// R12 - system holds fetch select low to fetch everything externally
// R13 - fetch select high: internal fetch unless address exceeds on-chip size
// R14 - with first security bit set, fetch select is latched at reset
// R15 - separate active-low write and read strobes for external data
// R16 - reset pin high two machine cycles resets the device
// R17 - machine cycle is twelve or six oscillator periods
// R18 - after reset run 12-clock unless nonvolatile option picks 6-clock
// R19 - external latch grabs low address on the latch strobe falling edge
// R20 - low address stays on the port until after the latch strobe falls
`timescale 1ns/10ps
module emb_bus #(
   parameter int unsigned ROM_BYTES = 4096
) (
   input wire logic mclk_i,
   input wire logic arst_n_i,
   input wire logic rst_pin_i,
   input wire logic x2_i,
   input wire logic nv_x2_i,
   input wire logic sec1_i,
   input wire logic external_fetch_select_i,
   input wire logic ale_dis_i,
   input wire emb_pkg::emb_cmd_t cmd_i,
   input wire logic [7:0] p0_latch_i,
   input wire logic [7:0] p2_latch_i,
   input wire logic [7:0] low_addr_data_port_i,
   output logic cyc_start_o,
   output logic dev_reset_o,
   output logic six_clk_mode_o,
   output logic rdata_valid_o,
   output logic [7:0] rdata_o,
   output logic ale_o,
   output logic code_read_strobe_n_o,
   output logic data_wr_strobe_n_o,
   output logic data_rd_strobe_n_o,
   output logic [7:0] low_addr_data_port_o,
   output logic [7:0] low_addr_data_port_oe_o,
   output logic [7:0] high_addr_port_o
);

   // ------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------
   logic [7:0] p0_sync;
   logic ea_sync;
   logic rst_sync;

   emb_sync #(.W(8)) u_sync_p0 (
      .mclk_i(mclk_i),
      .arst_n_i(arst_n_i),
      .d_i(low_addr_data_port_i),
      .q_o(p0_sync)
   );

   emb_sync #(.W(1)) u_sync_ea (
      .mclk_i(mclk_i),
      .arst_n_i(arst_n_i),
      .d_i(external_fetch_select_i),
      .q_o(ea_sync)
   );

   emb_sync #(.W(1)) u_sync_rst (
      .mclk_i(mclk_i),
      .arst_n_i(arst_n_i),
      .d_i(rst_pin_i),
      .q_o(rst_sync)
   );

   // ------------------------------------------------------------
   // reset qualification and fetch select capture
   // ------------------------------------------------------------
   logic [4:0] rst_cnt_r, rst_cnt_nxt;
   logic rst_int_r, rst_int_nxt;
   logic [1:0] cap_cnt_r, cap_cnt_nxt;
   logic ea_cap_r, ea_cap_nxt;
   logic six_r, six_nxt;
   logic [4:0] rst_thr;
   logic ea_eff;

   always_comb begin
      rst_thr = six_r ? emb_pkg::RST_OSC_6 : emb_pkg::RST_OSC_12; // R17
      rst_cnt_nxt = '0;
      if (rst_sync) begin
         rst_cnt_nxt = (rst_cnt_r == rst_thr) ? rst_cnt_r : rst_cnt_r + 5'h01;
      end
      rst_int_nxt = rst_sync && (rst_cnt_nxt == rst_thr); // R16
      cap_cnt_nxt = cap_cnt_r;
      ea_cap_nxt = ea_cap_r;
      if (rst_int_r) begin
         cap_cnt_nxt = '0;
      end else if (cap_cnt_r != emb_pkg::CAP_DONE) begin
         cap_cnt_nxt = cap_cnt_r + 2'h1;
      end
      // keep following the pin while in reset and just after it
      if (rst_int_r || cap_cnt_r != emb_pkg::CAP_DONE) begin
         ea_cap_nxt = ea_sync; // R14
      end
      ea_eff = sec1_i ? ea_cap_r : ea_sync; // R14
   end

   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rst_cnt_r <= '0;
         rst_int_r <= 1'b0;
         cap_cnt_r <= '0;
         ea_cap_r <= 1'b0;
      end else begin
         rst_cnt_r <= rst_cnt_nxt;
         rst_int_r <= rst_int_nxt;
         cap_cnt_r <= cap_cnt_nxt;
         ea_cap_r <= ea_cap_nxt;
      end
   end

   // ------------------------------------------------------------
   // machine cycle sequencer
   // ------------------------------------------------------------
   logic [3:0] ph_r, ph_nxt;
   emb_pkg::emb_state_t st_r, st_nxt;
   emb_pkg::emb_cmd_t cmd_r, cmd_nxt;
   logic [3:0] step;
   logic [4:0] ph_sum;
   logic wrap;
   logic in_rom;

   always_comb begin
      step = six_r ? emb_pkg::PH_STEP_6 : emb_pkg::PH_STEP_12; // R17
      ph_sum = {1'b0, ph_r} + {1'b0, step};
      wrap = ph_sum > {1'b0, emb_pkg::PH_LAST};
      in_rom = {1'b0, cmd_i.addr} < 17'(ROM_BYTES);
      ph_nxt = wrap ? emb_pkg::PH_FIRST : ph_sum[3:0];
      st_nxt = st_r;
      cmd_nxt = cmd_r;
      six_nxt = six_r;
      if (wrap) begin
         // mode changes only at a cycle boundary so phases stay aligned
         six_nxt = x2_i | nv_x2_i;
         cmd_nxt = cmd_i;
         unique case (cmd_i.kind)
            emb_pkg::CMD_IDLE: st_nxt = emb_pkg::ST_IDLE;
            emb_pkg::CMD_FETCH: st_nxt = (ea_eff && in_rom) ? emb_pkg::ST_INT
                                                            : emb_pkg::ST_EXT; // R12 R13
            emb_pkg::CMD_XRD, emb_pkg::CMD_XWR: st_nxt = emb_pkg::ST_EXTERNAL_MOVE_INSTRUCTION;
         endcase
      end
      if (rst_int_r) begin
         ph_nxt = emb_pkg::PH_FIRST;
         st_nxt = emb_pkg::ST_IDLE;
         cmd_nxt = emb_pkg::CMD_RST;
         six_nxt = nv_x2_i; // R18
      end
   end

   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ph_r <= emb_pkg::PH_FIRST;
         st_r <= emb_pkg::ST_IDLE;
         cmd_r <= emb_pkg::CMD_RST;
         six_r <= 1'b0; // R18
      end else begin
         ph_r <= ph_nxt;
         st_r <= st_nxt;
         cmd_r <= cmd_nxt;
         six_r <= six_nxt;
      end
   end

   assign cyc_start_o = wrap && !rst_int_r;
   assign dev_reset_o = rst_int_r;
   assign six_clk_mode_o = six_r;

   // ------------------------------------------------------------
   // pin drive, computed one cycle ahead so every pin is a flop
   // ------------------------------------------------------------
   emb_pkg::emb_pins_t pins_r, pins_nxt;
   logic half2;
   logic [3:0] rel;
   logic [15:0] faddr;
   logic ale_win;

   always_comb begin
      half2 = ph_nxt >= emb_pkg::PH_HALF;
      rel = half2 ? ph_nxt - emb_pkg::PH_HALF : ph_nxt;
      faddr = half2 ? cmd_nxt.addr + 16'h0001 : cmd_nxt.addr;
      ale_win = rel <= emb_pkg::PH_ALE_END; // R06
      pins_nxt = emb_pkg::PINS_RST;
      pins_nxt.ale = ale_win && !ale_dis_i; // R06 R08
      pins_nxt.p0_o = '0;
      pins_nxt.p0_oe = ~p0_latch_i; // R03
      pins_nxt.p2 = p2_latch_i;
      unique case (st_nxt)
         emb_pkg::ST_IDLE, emb_pkg::ST_INT: begin
            pins_nxt.code_read_strobe_n = 1'b1; // R11
         end
         emb_pkg::ST_EXT: begin
            pins_nxt.p2 = faddr[15:8]; // R04
            if (rel <= emb_pkg::PH_ADDR_END) begin
               pins_nxt.p0_o = faddr[7:0]; // R01 R20
               pins_nxt.p0_oe = 8'hff; // R02
            end else begin
               pins_nxt.p0_oe = 8'h00;
               pins_nxt.code_read_strobe_n = 1'b0; // R09
            end
         end
         emb_pkg::ST_EXTERNAL_MOVE_INSTRUCTION: begin
            // second latch pulse and both code reads are dropped here
            pins_nxt.ale = ph_nxt <= emb_pkg::PH_ALE_END; // R07 R08 R10
            pins_nxt.p2 = cmd_nxt.wide ? cmd_nxt.addr[15:8] : p2_latch_i; // R04 R05
            if (ph_nxt <= emb_pkg::PH_ADDR_END) begin
               pins_nxt.p0_o = cmd_nxt.addr[7:0]; // R01 R20
               pins_nxt.p0_oe = 8'hff; // R02
            end else if (cmd_nxt.kind == emb_pkg::CMD_XWR) begin
               pins_nxt.p0_o = cmd_nxt.wdata; // R01
               pins_nxt.p0_oe = 8'hff; // R02
               pins_nxt.wr_n = ph_nxt > emb_pkg::PH_WR_END; // R15
            end else begin
               pins_nxt.p0_oe = 8'h00;
               pins_nxt.rd_n = 1'b0; // R15
            end
         end
      endcase
      if (rst_int_r) begin
         pins_nxt = emb_pkg::PINS_RST;
      end
   end

   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         pins_r <= emb_pkg::PINS_RST;
      end else begin
         pins_r <= pins_nxt;
      end
   end

   assign ale_o = pins_r.ale;
   assign code_read_strobe_n_o = pins_r.code_read_strobe_n;
   assign data_wr_strobe_n_o = pins_r.wr_n;
   assign data_rd_strobe_n_o = pins_r.rd_n;
   assign low_addr_data_port_o = pins_r.p0_o;
   assign low_addr_data_port_oe_o = pins_r.p0_oe;
   assign high_addr_port_o = pins_r.p2;

   // ------------------------------------------------------------
   // read data capture, delayed to match the port synchroniser
   // ------------------------------------------------------------
   logic smp_now;
   logic smp_d1_r, smp_d1_nxt;
   logic smp_d2_r, smp_d2_nxt;
   logic [7:0] rdata_r, rdata_nxt;
   // valid is raised with the byte, not one cycle ahead of it
   logic val_r, val_nxt;

   always_comb begin
      smp_now = !rst_int_r && (
         (st_r == emb_pkg::ST_EXT &&
          (wrap || (ph_r < emb_pkg::PH_HALF && ph_sum >= {1'b0, emb_pkg::PH_HALF}))) ||
         (st_r == emb_pkg::ST_EXTERNAL_MOVE_INSTRUCTION && cmd_r.kind == emb_pkg::CMD_XRD && wrap));
      smp_d1_nxt = smp_now;
      smp_d2_nxt = smp_d1_r;
      rdata_nxt = smp_d2_r ? p0_sync : rdata_r;
      val_nxt = smp_d2_r;
   end

   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         smp_d1_r <= 1'b0;
         smp_d2_r <= 1'b0;
         rdata_r <= '0;
         val_r <= 1'b0;
      end else begin
         smp_d1_r <= smp_d1_nxt;
         smp_d2_r <= smp_d2_nxt;
         rdata_r <= rdata_nxt;
         val_r <= val_nxt;
      end
   end

   assign rdata_o = rdata_r;
   assign rdata_valid_o = val_r;

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   logic ale_win_r;
   assign ale_win_r = ph_r <= emb_pkg::PH_ALE_END ||
                      (ph_r >= emb_pkg::PH_HALF && ph_r <= emb_pkg::PH_ALE2_END);

   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!arst_n_i);

   sequence s_code_read_strobe_low3;
      !code_read_strobe_n_o [*3];
   endsequence

   sequence s_code_read_strobe_pair;
      s_code_read_strobe_low3 ##1 code_read_strobe_n_o [*3] ##1 s_code_read_strobe_low3;
   endsequence

   AST_MUX_ADDR: assert property ( // R01
      st_r == emb_pkg::ST_EXTERNAL_MOVE_INSTRUCTION && ph_r == emb_pkg::PH_FIRST |->
         low_addr_data_port_o == cmd_r.addr[7:0])
      else $error("low address missing at start of data move");

   AST_STRONG_ONES: assert property ( // R02
      st_r == emb_pkg::ST_EXT && ph_r <= emb_pkg::PH_ADDR_END && !$past(rst_int_r) |->
         low_addr_data_port_oe_o == 8'hff)
      else $error("address phase not fully driven");

   AST_PORT_FLOAT: assert property ( // R03
      st_r == emb_pkg::ST_IDLE && !$past(rst_int_r) |->
         low_addr_data_port_oe_o == ~$past(p0_latch_i))
      else $error("port drive does not follow latch outside bus cycles");

   AST_HI_ADDR: assert property ( // R04
      st_r == emb_pkg::ST_EXTERNAL_MOVE_INSTRUCTION && cmd_r.wide && !$past(rst_int_r) |->
         high_addr_port_o == cmd_r.addr[15:8])
      else $error("high address byte wrong on wide move");

   AST_HI_LATCH: assert property ( // R05
      st_r == emb_pkg::ST_EXTERNAL_MOVE_INSTRUCTION && !cmd_r.wide && !$past(rst_int_r) |->
         high_addr_port_o == $past(p2_latch_i))
      else $error("narrow move did not show the high port latch");

   AST_ALE_RATE: assert property ( // R06
      st_r != emb_pkg::ST_EXTERNAL_MOVE_INSTRUCTION && !$past(ale_dis_i) && !$past(rst_int_r) && $past(arst_n_i) |->
         ale_o == ale_win_r)
      else $error("latch strobe off its regular phase");

   AST_ALE_SKIP: assert property ( // R07
      st_r == emb_pkg::ST_EXTERNAL_MOVE_INSTRUCTION && ph_r == emb_pkg::PH_HALF |-> !ale_o)
      else $error("latch pulse not skipped in data move");

   AST_ALE_OFF: assert property ( // R08
      st_r != emb_pkg::ST_EXTERNAL_MOVE_INSTRUCTION && $past(ale_dis_i) |-> !ale_o)
      else $error("latch strobe active while disabled");

   AST_CODE_READ_STROBE_TWICE: assert property ( // R09
      disable iff (!arst_n_i || rst_int_r)
      st_r == emb_pkg::ST_EXT && ph_r == emb_pkg::PH_STB_FIRST && !six_r |-> s_code_read_strobe_pair)
      else $error("code read strobe not twice per machine cycle");

   AST_CODE_READ_STROBE_QUIET: assert property ( // R10 R11
      st_r == emb_pkg::ST_EXTERNAL_MOVE_INSTRUCTION || st_r == emb_pkg::ST_INT |-> code_read_strobe_n_o)
      else $error("code read strobe during data move or internal fetch");

   AST_EA_LOCK: assert property ( // R14
      sec1_i && cap_cnt_r == emb_pkg::CAP_DONE && !rst_int_r |=> $stable(ea_cap_r))
      else $error("latched fetch select changed after reset");

   AST_RD_STROBE: assert property ( // R15
      st_r == emb_pkg::ST_EXTERNAL_MOVE_INSTRUCTION && cmd_r.kind == emb_pkg::CMD_XRD &&
      ph_r > emb_pkg::PH_ADDR_END && !$past(rst_int_r) |->
         !data_rd_strobe_n_o && data_wr_strobe_n_o && low_addr_data_port_oe_o == 8'h00)
      else $error("read strobe or port release wrong");

   AST_RST_LEN: assert property ( // R16
      $rose(rst_int_r) |-> $past(rst_cnt_r) == rst_thr - 5'h01)
      else $error("reset taken without two machine cycles of pin");

   AST_ADDR_HOLD: assert property ( // R20
      $fell(ale_o) && st_r == emb_pkg::ST_EXT |->
         low_addr_data_port_oe_o == 8'hff &&
         low_addr_data_port_o == $past(low_addr_data_port_o))
      else $error("address released before latch strobe fell");

endmodule // emb_bus

// ===== verif/emb_mem_model.sv
// far side of the bus: address latch, code memory and data memory
// assumes registered strobes from the block; the port pin is resolved here
`timescale 1ns/10ps
module emb_mem_model (
   input wire logic mclk_i,
   input wire logic ale_i,
   input wire logic code_read_strobe_n_i,
   input wire logic data_wr_strobe_n_i,
   input wire logic data_rd_strobe_n_i,
   input wire logic [7:0] port_drv_i,
   input wire logic [7:0] port_oe_i,
   input wire logic [7:0] high_addr_port_i,
   output logic [7:0] pin_o,
   output logic [15:0] acc_addr_o
);
   // ------------------------------------------------------------
   // latch and memories
   // ------------------------------------------------------------
   logic [7:0] lat_lo = 8'h00;
   logic [7:0] last_pin = 8'h00;
   logic [7:0] mem_val;
   logic mem_en;
   logic [7:0] dmem [0:65535];
   initial acc_addr_o = 16'h0000;
   always @(negedge ale_i) lat_lo = pin_o;
   always @(negedge code_read_strobe_n_i or negedge data_rd_strobe_n_i
            or negedge data_wr_strobe_n_i) acc_addr_o = {high_addr_port_i, lat_lo};
   always @(posedge data_wr_strobe_n_i) dmem[acc_addr_o] = pin_o;
   // memory drives only while a read strobe is low, never after it rises
   assign mem_en = !code_read_strobe_n_i || !data_rd_strobe_n_i;
   assign mem_val = !code_read_strobe_n_i ? (acc_addr_o[7:0] ^ acc_addr_o[15:8] ^ 8'h5a)
                                          : dmem[acc_addr_o];
   // a floating open-drain line shows a changing pattern, not its last value
   always @(posedge mclk_i) last_pin <= pin_o;
   always_comb begin
      for (int i = 0; i < 8; i++) pin_o[i] = port_oe_i[i] ? port_drv_i[i]
                                             : (mem_en ? mem_val[i] : ~last_pin[i]);
   end
endmodule // emb_mem_model

// ===== verif/tb.sv
// self-checking bench for the external memory bus block
// assumes the block answers one command per machine cycle at cyc_start_o
`timescale 1ns/10ps
module tb;
   logic mclk_i = 1'b0;
   logic arst_n_i = 1'b0;
   logic rst_pin_i = 1'b0;
   logic x2_i = 1'b0;
   logic nv_x2_i = 1'b0;
   logic sec1_i = 1'b0;
   logic external_fetch_select_i = 1'b1;
   logic ale_dis_i = 1'b0;
   emb_pkg::emb_cmd_t cmd_i = emb_pkg::CMD_RST;
   logic [7:0] p0_latch_i = 8'hff;
   logic [7:0] p2_latch_i = 8'hff;
   logic [7:0] pin;
   logic [15:0] acc;
   logic cyc_start_o, dev_reset_o, six_clk_mode_o, rdata_valid_o, ale_o;
   logic code_read_strobe_n_o, data_wr_strobe_n_o, data_rd_strobe_n_o;
   logic [7:0] rdata_o, port_drv, port_oe, high_addr_port_o;
   int n_mismatch = 0;
   int comparisons = 0;
   int n_ale = 0, n_code_read_strobe = 0, n_rd = 0, n_wr = 0, cyc = 0, mlen = 12;
   int da, dp, dr, dw;
   logic ale_q = 1'b0, code_read_strobe_q = 1'b1, rd_q = 1'b1, wr_q = 1'b1;
   logic [7:0] rq [$];

   emb_bus uut (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .rst_pin_i(rst_pin_i), .x2_i(x2_i),
      .nv_x2_i(nv_x2_i), .sec1_i(sec1_i), .external_fetch_select_i(external_fetch_select_i),
      .ale_dis_i(ale_dis_i), .cmd_i(cmd_i), .p0_latch_i(p0_latch_i), .p2_latch_i(p2_latch_i),
      .low_addr_data_port_i(pin), .cyc_start_o(cyc_start_o), .dev_reset_o(dev_reset_o),
      .six_clk_mode_o(six_clk_mode_o), .rdata_valid_o(rdata_valid_o), .rdata_o(rdata_o),
      .ale_o(ale_o), .code_read_strobe_n_o(code_read_strobe_n_o),
      .data_wr_strobe_n_o(data_wr_strobe_n_o), .data_rd_strobe_n_o(data_rd_strobe_n_o),
      .low_addr_data_port_o(port_drv), .low_addr_data_port_oe_o(port_oe),
      .high_addr_port_o(high_addr_port_o));

   emb_mem_model mem (.mclk_i(mclk_i), .ale_i(ale_o), .code_read_strobe_n_i(code_read_strobe_n_o),
      .data_wr_strobe_n_i(data_wr_strobe_n_o), .data_rd_strobe_n_i(data_rd_strobe_n_o),
      .port_drv_i(port_drv), .port_oe_i(port_oe), .high_addr_port_i(high_addr_port_o),
      .pin_o(pin), .acc_addr_o(acc));

   // ------------------------------------------------------------
   // clock, edge counters and timeout
   // ------------------------------------------------------------
   always #5 mclk_i = ~mclk_i;
   always @(posedge mclk_i) begin
      cyc++;
      if (ale_o && !ale_q) n_ale++;
      if (!code_read_strobe_n_o && code_read_strobe_q) n_code_read_strobe++;
      if (!data_rd_strobe_n_o && rd_q) n_rd++;
      if (!data_wr_strobe_n_o && wr_q) n_wr++;
      ale_q = ale_o;
      code_read_strobe_q = code_read_strobe_n_o;
      rd_q = data_rd_strobe_n_o;
      wr_q = data_wr_strobe_n_o;
      if (rdata_valid_o === 1'b1) rq.push_back(rdata_o);
      if (cyc == 20000) begin
         n_mismatch++;
         give_verdict();
      end
   end

   // ------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   function automatic logic [7:0] cb(input logic [15:0] a);
      return a[7:0] ^ a[15:8] ^ 8'h5a;
   endfunction

   // waits out one boundary, offers the command for the next one, then counts strobes
   // over two machine cycles: the issued one and an idle one after it
   task automatic bus_op(input emb_pkg::emb_kind_t k, input logic w, input logic [15:0] a,
                         input logic [7:0] d);
      int a0, p0, r0, w0, t;
      t = 0;
      while (cyc_start_o !== 1'b1 && t < 100) begin
         @(negedge mclk_i);
         t++;
      end
      @(posedge mclk_i);
      cmd_i <= '{kind: k, wide: w, addr: a, wdata: d};
      @(negedge mclk_i);
      while (cyc_start_o !== 1'b1 && t < 100) begin
         @(negedge mclk_i);
         t++;
      end
      @(posedge mclk_i);
      cmd_i <= emb_pkg::CMD_RST;
      #1;
      a0 = n_ale;
      p0 = n_code_read_strobe;
      r0 = n_rd;
      w0 = n_wr;
      rq.delete();
      repeat (2 * mlen) @(posedge mclk_i);
      #1;
      da = n_ale - a0;
      dp = n_code_read_strobe - p0;
      dr = n_rd - r0;
      dw = n_wr - w0;
   endtask

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_mode(input logic m);
      int a0;
      x2_i <= m;
      mlen = m ? 6 : 12;
      repeat (36) @(posedge mclk_i);
      check("six clock mode", six_clk_mode_o, m);
      a0 = n_ale;
      repeat (24) @(posedge mclk_i);
      check("idle latch pulses in 24 clocks", n_ale - a0, m ? 8 : 4);
      bus_op(emb_pkg::CMD_FETCH, 1'b0, 16'h12ff, 8'h00);
      check("code strobes", dp, 2);
      check("latch pulses around fetch", da, m ? 4 : 4);
      check("fetched byte count", rq.size(), 2);
      check("first byte", rq.size() > 0 ? rq[0] : 8'h00, cb(16'h12ff));
      check("second byte", rq.size() > 1 ? rq[1] : 8'h00, cb(16'h1300));
      check("fetch address", acc, 16'h1300);
   endtask

   task automatic t_internal();
      bus_op(emb_pkg::CMD_FETCH, 1'b0, 16'h0fff, 8'h00);
      check("strobes on top internal address", dp, 0);
      check("bytes on internal fetch", rq.size(), 0);
      bus_op(emb_pkg::CMD_FETCH, 1'b0, 16'h1000, 8'h00);
      check("strobes above internal size", dp, 2);
      external_fetch_select_i <= 1'b0;
      repeat (10) @(posedge mclk_i);
      bus_op(emb_pkg::CMD_FETCH, 1'b0, 16'h0100, 8'h00);
      check("strobes with select low", dp, 2);
      check("low fetch byte", rq.size() > 0 ? rq[0] : 8'h00, cb(16'h0100));
      external_fetch_select_i <= 1'b1;
      repeat (10) @(posedge mclk_i);
   endtask

   task automatic t_move();
      p2_latch_i <= 8'ha5;
      bus_op(emb_pkg::CMD_XWR, 1'b0, 16'h0042, 8'h96);
      check("write strobes", dw, 1);
      check("code strobes in write", dp, 0);
      check("latch pulses in write", da, 3);
      check("narrow write address", acc, 16'ha542);
      p2_latch_i <= 8'h3c;
      bus_op(emb_pkg::CMD_XRD, 1'b1, 16'ha542, 8'h00);
      check("read strobes", dr, 1);
      check("code strobes in read", dp, 0);
      check("latch pulses in read", da, 3);
      check("wide read address", acc, 16'ha542);
      check("read byte", rq.size() > 0 ? rq[0] : 8'h00, 8'h96);
   endtask

   task automatic t_ale_off();
      int a0;
      ale_dis_i <= 1'b1;
      p0_latch_i <= 8'hf0;
      repeat (12) @(posedge mclk_i);
      a0 = n_ale;
      repeat (24) @(posedge mclk_i);
      check("latch pulses while disabled", n_ale - a0, 0);
      check("idle port drive enables", port_oe, 8'h0f);
      bus_op(emb_pkg::CMD_XRD, 1'b1, 16'ha542, 8'h00);
      check("latch pulses in disabled move", da, 1);
      check("disabled move byte", rq.size() > 0 ? rq[0] : 8'h00, 8'h96);
      ale_dis_i <= 1'b0;
      p0_latch_i <= 8'hff;
   endtask

   task automatic t_reset_pin();
      logic hit;
      sec1_i <= 1'b1;
      rst_pin_i <= 1'b1;
      repeat (20) @(posedge mclk_i);
      rst_pin_i <= 1'b0;
      hit = 1'b0;
      repeat (8) begin
         @(negedge mclk_i);
         hit |= dev_reset_o;
      end
      check("reset after short pulse", hit, 1'b0);
      @(posedge mclk_i);
      rst_pin_i <= 1'b1;
      repeat (30) @(posedge mclk_i);
      #1;
      check("reset after long pulse", dev_reset_o, 1'b1);
      check("latch strobe in reset", ale_o, 1'b0);
      @(posedge mclk_i);
      rst_pin_i <= 1'b0;
      repeat (10) @(posedge mclk_i);
      #1;
      check("reset released", dev_reset_o, 1'b0);
      check("mode after reset", six_clk_mode_o, 1'b0);
      external_fetch_select_i <= 1'b0;
      repeat (10) @(posedge mclk_i);
      bus_op(emb_pkg::CMD_FETCH, 1'b0, 16'h0100, 8'h00);
      check("strobes with captured select", dp, 0);
      sec1_i <= 1'b0;
      repeat (10) @(posedge mclk_i);
      bus_op(emb_pkg::CMD_FETCH, 1'b0, 16'h0100, 8'h00);
      check("strobes with live select", dp, 2);
      external_fetch_select_i <= 1'b1;
      repeat (10) @(posedge mclk_i);
   endtask

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (4) @(posedge mclk_i);
      #1;
      check("port enables in reset", port_oe, 8'h00);
      check("high port in reset", high_addr_port_o, 8'hff);
      @(posedge mclk_i);
      arst_n_i <= 1'b1;
      repeat (30) @(posedge mclk_i);
      t_mode(1'b0);
      t_internal();
      t_move();
      t_ale_off();
      t_mode(1'b1);
      t_mode(1'b0);
      t_reset_pin();
      give_verdict();
   end
endmodule // tb
